// ==== core/on_chip_external_ram_sfr_pkg.sv ====
`default_nettype none
package on_chip_external_ram_sfr_pkg;
  // Special-function window and register addresses.
  localparam logic [7:0] SFR_WINDOW_BASE    = 8'h80;
  localparam logic [7:0] ADDR_DP_LOW        = 8'h82;
  localparam logic [7:0] ADDR_DP_HIGH       = 8'h83;
  localparam logic [7:0] ADDR_PAGE_SELECT   = 8'hA7;
  localparam logic [7:0] ADDR_ON_CHIP_EXTERNAL_RAM_PAGE     = 8'hAA;
  // Register pages.
  localparam logic [7:0] SFR_PAGE_MAIN      = 8'h00;
  localparam logic [7:0] SFR_PAGE_ALT       = 8'h0F;
  // Reset values.
  localparam logic [7:0] RESET_PAGE_SELECT  = 8'h00;
  localparam logic [7:0] RESET_ON_CHIP_EXTERNAL_RAM_PAGE    = 8'h00;
  localparam logic [7:0] RESET_DP_BYTE      = 8'h00;
  // Field layout of the page control register.
  localparam int         ON_CHIP_EXTERNAL_RAM_PAGE_BIT_POS  = 0;
  // Low three address bits of bit-addressable registers.
  localparam logic [2:0] BIT_ADDR_LOW_BITS  = 3'h0;
  // Storage size of the on-chip external RAM.
  localparam int         ON_CHIP_EXTERNAL_RAM_DEPTH         = 512;
  // Move instructions complete with no added wait states.
  localparam int         ON_CHIP_EXTERNAL_RAM_WAIT_STATES   = 0;
  // Source of the move instruction address.
  typedef enum logic {
    MOVE_BY_POINTER,
    MOVE_BY_INDEX
  } move_form_e;
endpackage : on_chip_external_ram_sfr_pkg
`default_nettype wire

// ==== core/on_chip_external_ram_store.sv ====
`default_nettype none
module on_chip_external_ram_store
  import on_chip_external_ram_sfr_pkg::*;
#(
  parameter int DEPTH = ON_CHIP_EXTERNAL_RAM_DEPTH,
  parameter int AW    = 9
) (
  // Clock, reset and enable.
  input  wire logic          clk_sys_in,
  input  wire logic          rst_n_in,
  input  wire logic          clk_en_in,
  // Access port.
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    wdata_in,
  output logic      [7:0]    rdata_out
);

  logic [7:0] mem_q [DEPTH];

  // Each byte is one flip-flop entry written when its index is selected.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        mem_q[i] <= 8'h00;
      end else if (clk_en_in && wr_en_in && addr_in == AW'(i)) begin
        mem_q[i] <= wdata_in;
      end
    end
  end

  // Read port is combinational; the owner registers it with its range gate.
  assign rdata_out = mem_q[addr_in];

endmodule : on_chip_external_ram_store
`default_nettype wire

// ==== core/on_chip_external_ram_and_sfr_access_decode.sv ====
// Functional notes
// - Pointer-form external moves use the full 16-bit data pointer as address.
// - Indexed moves take high byte from page register, low byte from index register.
// - Data pointer is exposed as separate high and low byte registers.
// - External moves target on-chip external RAM by default after reset.
// - External RAM needs no setup and adds no wait states.
// - Page register bits 7:1 read zero; writes to them are ignored.
// - Page bit selects 256-byte page: one gives 0x0100-0x01FF, zero 0x0000-0x00FF.
// - Indexed high address byte is seven zeros then the page bit.
// - Page register sits at 0xAA on page 0x0, read/write, resets zero.
// - Direct accesses to 0x80-0xFF go to register space, not data RAM.
// - Registers at low nibble 0x0 or 0x8 allow bit access; others byte only.
// - Target chosen from register page value together with direct address.
// - After reset register accesses target page 0x0.
// - Page select and data pointer decode identically on pages 0x0 and 0xF.
// - Page select is 8-bit read/write at 0xA7, all pages, resets zero.
// - On-chip external RAM holds 512 bytes.
`default_nettype none
module on_chip_external_ram_and_sfr_access_decode
  import on_chip_external_ram_sfr_pkg::*;
#(
  parameter int ON_CHIP_EXTERNAL_RAM_BYTES = ON_CHIP_EXTERNAL_RAM_DEPTH,
  parameter int ON_CHIP_EXTERNAL_RAM_AW    = 9
) (
  // Clock, reset and enable.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  // Direct register access from the core.
  input  wire logic        sfr_rd_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_bit_in,
  input  wire logic [2:0]  sfr_bit_pos_in,
  input  wire logic [7:0]  direct_addr_in,
  input  wire logic [7:0]  sfr_wdata_in,
  // External move request from the core.
  input  wire logic        move_rd_in,
  input  wire logic        move_wr_in,
  input  wire logic        move_form_in,
  input  wire logic [7:0]  index_reg_in,
  input  wire logic [7:0]  move_wdata_in,
  // Register access results.
  output logic      [7:0]  sfr_rdata_out,
  output logic             sfr_rvalid_out,
  output logic             sfr_hit_out,
  output logic             sfr_bit_ok_out,
  output logic      [7:0]  register_page_select_out,
  output logic      [15:0] data_pointer_out,
  output logic             on_chip_external_ram_page_bit_out,
  // External move results.
  output logic      [15:0] move_addr_out,
  output logic      [7:0]  move_rdata_out,
  output logic             move_done_out
);

  // Register state.
  logic [7:0]  page_sel_q;
  logic        on_chip_external_ram_page_bit_q;
  logic [7:0]  dp_high_q;
  logic [7:0]  dp_low_q;
  logic [7:0]  sfr_rdata_q;
  logic        sfr_rvalid_q;
  logic        sfr_hit_q;
  logic        sfr_bit_ok_q;
  logic [15:0] move_addr_q;
  logic        move_done_q;
  logic [7:0]  move_rdata_q;

  // Decode signals.
  logic        in_window;
  logic        on_main_page;
  logic        on_shared_page;
  logic        hit_dp_low;
  logic        hit_dp_high;
  logic        hit_page_sel;
  logic        hit_on_chip_external_ram_page;
  logic        reg_hit;
  logic        bit_capable;
  logic        bit_access_ok;
  logic        do_write;
  logic [7:0]  cur_byte;
  logic [7:0]  write_byte;
  logic [15:0] eff_addr;
  logic        in_range;
  logic        move_req;
  logic        move_wr_ok;
  logic [7:0]  on_chip_external_ram_rdata;

  // Window and page decode; paging selects among register sets.
  assign in_window      = direct_addr_in[7];
  assign on_main_page   = (page_sel_q == SFR_PAGE_MAIN);
  assign on_shared_page = on_main_page || (page_sel_q == SFR_PAGE_ALT);

  // Address matches; shared registers respond on both pages.
  assign hit_dp_low    = in_window && on_shared_page &&
                         direct_addr_in == ADDR_DP_LOW;
  assign hit_dp_high   = in_window && on_shared_page &&
                         direct_addr_in == ADDR_DP_HIGH;
  assign hit_page_sel  = in_window && direct_addr_in == ADDR_PAGE_SELECT;
  assign hit_on_chip_external_ram_page = in_window && on_main_page &&
                         direct_addr_in == ADDR_ON_CHIP_EXTERNAL_RAM_PAGE;
  assign reg_hit       = hit_dp_low || hit_dp_high || hit_page_sel || hit_on_chip_external_ram_page;

  // Bit access is legal only at addresses whose low three bits are zero.
  assign bit_capable   = (direct_addr_in[2:0] == BIT_ADDR_LOW_BITS);
  assign bit_access_ok = !sfr_bit_in || bit_capable;
  assign do_write      = clk_en_in && sfr_wr_in && reg_hit && bit_access_ok;

  // Current byte of the addressed register; reserved slots read zero.
  always_comb begin
    cur_byte = 8'h00;
    if (hit_dp_low) begin
      cur_byte = dp_low_q;
    end else if (hit_dp_high) begin
      cur_byte = dp_high_q;
    end else if (hit_page_sel) begin
      cur_byte = page_sel_q;
    end else if (hit_on_chip_external_ram_page) begin
      cur_byte = {7'h00, on_chip_external_ram_page_bit_q};
    end
  end

  // A bit write modifies one bit of the current byte, a byte write replaces it.
  always_comb begin
    write_byte = sfr_wdata_in;
    if (sfr_bit_in) begin
      write_byte = cur_byte;
      write_byte[sfr_bit_pos_in] = sfr_wdata_in[0];
    end
  end

  // Register page select; page 0x0 after reset.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_sel_q <= RESET_PAGE_SELECT;
    end else if (do_write && hit_page_sel) begin
      page_sel_q <= write_byte;
    end
  end

  // Page control register keeps only its page bit.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_chip_external_ram_page_bit_q <= RESET_ON_CHIP_EXTERNAL_RAM_PAGE[ON_CHIP_EXTERNAL_RAM_PAGE_BIT_POS];
    end else if (do_write && hit_on_chip_external_ram_page) begin
      on_chip_external_ram_page_bit_q <= write_byte[ON_CHIP_EXTERNAL_RAM_PAGE_BIT_POS];
    end
  end

  // Data pointer bytes.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dp_high_q <= RESET_DP_BYTE;
      dp_low_q  <= RESET_DP_BYTE;
    end else begin
      if (do_write && hit_dp_high) begin
        dp_high_q <= write_byte;
      end
      if (do_write && hit_dp_low) begin
        dp_low_q <= write_byte;
      end
    end
  end

  // Register read answer one cycle after the request.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sfr_rdata_q  <= 8'h00;
      sfr_rvalid_q <= 1'b0;
      sfr_hit_q    <= 1'b0;
      sfr_bit_ok_q <= 1'b0;
    end else if (clk_en_in) begin
      sfr_rvalid_q <= sfr_rd_in;
      sfr_hit_q    <= (sfr_rd_in || sfr_wr_in) && reg_hit;
      sfr_bit_ok_q <= (sfr_rd_in || sfr_wr_in) && in_window && bit_capable;
      if (sfr_rd_in) begin
        if (!bit_access_ok) begin
          sfr_rdata_q <= 8'h00;
        end else if (sfr_bit_in) begin
          sfr_rdata_q <= {7'h00, cur_byte[sfr_bit_pos_in]};
        end else begin
          sfr_rdata_q <= cur_byte;
        end
      end
    end
  end

  // Effective move address from pointer or page bit plus index register.
  always_comb begin
    unique case (move_form_e'(move_form_in))
      MOVE_BY_POINTER: eff_addr = {dp_high_q, dp_low_q};
      MOVE_BY_INDEX:   eff_addr = {7'h00, on_chip_external_ram_page_bit_q, index_reg_in};
    endcase
  end

  // Addresses past the store read zero and drop writes.
  assign in_range   = (eff_addr < 16'(ON_CHIP_EXTERNAL_RAM_BYTES));
  assign move_req   = move_rd_in || move_wr_in;
  assign move_wr_ok = move_wr_in && in_range;

  // Move completes the cycle after it is issued, with no wait states.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      move_addr_q  <= 16'h0000;
      move_done_q  <= 1'b0;
      move_rdata_q <= 8'h00;
    end else if (clk_en_in) begin
      move_done_q <= move_req && (ON_CHIP_EXTERNAL_RAM_WAIT_STATES == 0);
      if (move_req) begin
        move_addr_q <= eff_addr;
        // Addresses past the store read zero; the read sees pre-write data.
        move_rdata_q <= in_range ? on_chip_external_ram_rdata : 8'h00;
      end
    end
  end

  // On-chip external RAM; it is the only move target in this block.
  on_chip_external_ram_store #(
    .DEPTH (ON_CHIP_EXTERNAL_RAM_BYTES),
    .AW    (ON_CHIP_EXTERNAL_RAM_AW)
  ) u_store (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .wr_en_in   (move_wr_ok),
    .addr_in    (eff_addr[ON_CHIP_EXTERNAL_RAM_AW-1:0]),
    .wdata_in   (move_wdata_in),
    .rdata_out  (on_chip_external_ram_rdata)
  );

  // Registered outputs.
  assign sfr_rdata_out            = sfr_rdata_q;
  assign sfr_rvalid_out           = sfr_rvalid_q;
  assign sfr_hit_out              = sfr_hit_q;
  assign sfr_bit_ok_out           = sfr_bit_ok_q;
  assign register_page_select_out = page_sel_q;
  assign data_pointer_out         = {dp_high_q, dp_low_q};
  assign on_chip_external_ram_page_bit_out        = on_chip_external_ram_page_bit_q;
  assign move_addr_out            = move_addr_q;
  assign move_rdata_out           = move_rdata_q;
  assign move_done_out            = move_done_q;

endmodule : on_chip_external_ram_and_sfr_access_decode
`default_nettype wire

// ==== testbench/on_chip_external_ram_and_sfr_access_decode_sva.sv ====
`default_nettype none
module on_chip_external_ram_and_sfr_access_decode_sva
  import on_chip_external_ram_sfr_pkg::*;
(
  // Block inputs.
  input wire logic        clk_sys_in, rst_n_in, clk_en_in, sfr_rd_in, sfr_wr_in, sfr_bit_in,
  input wire logic [2:0]  sfr_bit_pos_in,
  input wire logic [7:0]  direct_addr_in, sfr_wdata_in, index_reg_in, move_wdata_in,
  input wire logic        move_rd_in, move_wr_in, move_form_in,
  // Block outputs.
  input wire logic [7:0]  sfr_rdata_out, register_page_select_out, move_rdata_out,
  input wire logic        sfr_rvalid_out, sfr_hit_out, sfr_bit_ok_out, on_chip_external_ram_page_bit_out,
  input wire logic [15:0] data_pointer_out, move_addr_out,
  input wire logic        move_done_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Requests as the block takes them, and the page now selected.
  logic rd, wr, mv, pg0, dp_pg;
  assign rd = clk_en_in && sfr_rd_in;
  assign wr = clk_en_in && sfr_wr_in && !sfr_bit_in;
  assign mv = clk_en_in && (move_rd_in || move_wr_in);
  assign pg0 = register_page_select_out == SFR_PAGE_MAIN;
  assign dp_pg = pg0 || register_page_select_out == SFR_PAGE_ALT;
  rd_answer_a: assert property (1 |=> sfr_rvalid_out == $past(rd))
    else $error("read answer missing or extra");
  move_done_a: assert property (mv |=> move_done_out)
    else $error("move not done in one cycle");
  ptr_addr_a: assert property (mv && !move_form_in |=> move_addr_out == $past(data_pointer_out))
    else $error("pointer move address wrong");
  idx_addr_a: assert property (mv && move_form_in |=>
    move_addr_out == {7'h00, $past(on_chip_external_ram_page_bit_out), $past(index_reg_in)})
    else $error("indexed move address wrong");
  page_sel_a: assert property (wr && direct_addr_in == ADDR_PAGE_SELECT |=>
    register_page_select_out == $past(sfr_wdata_in)) else $error("page select not written");
  page_bit_a: assert property (wr && pg0 && direct_addr_in == ADDR_ON_CHIP_EXTERNAL_RAM_PAGE |=>
    on_chip_external_ram_page_bit_out == $past(sfr_wdata_in[0])) else $error("page bit not written");
  page_rd_a: assert property (rd && !sfr_bit_in && pg0 && direct_addr_in == ADDR_ON_CHIP_EXTERNAL_RAM_PAGE |=>
    sfr_rdata_out == {7'h00, on_chip_external_ram_page_bit_out}) else $error("page register read wrong");
  dp_rd_a: assert property (rd && !sfr_bit_in && dp_pg && direct_addr_in == ADDR_DP_HIGH |=>
    sfr_hit_out && sfr_rdata_out == data_pointer_out[15:8]) else $error("pointer read wrong");
  window_a: assert property ((rd || sfr_wr_in) && !direct_addr_in[7] |=> !sfr_hit_out)
    else $error("hit below register window");
  bit_ok_a: assert property (rd && direct_addr_in[7] |=>
    sfr_bit_ok_out == ($past(direct_addr_in[2:0]) == BIT_ADDR_LOW_BITS))
    else $error("bit capability wrong");
  reserved_a: assert property (rd && direct_addr_in == 8'hAB |=>
    !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("reserved read not zero");
  alt_page_a: assert property (rd && !dp_pg && direct_addr_in == ADDR_DP_LOW |=> !sfr_hit_out)
    else $error("pointer hit on foreign page");
  // Main scenarios reached.
  cover property (mv && move_form_in);
  cover property (rd && register_page_select_out == SFR_PAGE_ALT);
  cover property (wr && direct_addr_in == ADDR_ON_CHIP_EXTERNAL_RAM_PAGE);
endmodule : on_chip_external_ram_and_sfr_access_decode_sva
bind on_chip_external_ram_and_sfr_access_decode on_chip_external_ram_and_sfr_access_decode_sva sva_i (.*);
`default_nettype wire

// ==== testbench/core_model.sv ====
`default_nettype none
module core_model
  import on_chip_external_ram_sfr_pkg::*;
(
  // Clock.
  input wire logic        clk_sys_in,
  // Direct access and move requests.
  output logic            sfr_rd_out, sfr_wr_out, sfr_bit_out,
  output logic      [7:0] addr_out, sfr_wdata_out, index_out, move_wdata_out,
  output logic            move_rd_out, move_wr_out, move_form_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic gie_q, gie_save;
  // Idle requests at time zero, interrupts on.
  initial begin
    {sfr_rd_out, sfr_wr_out, sfr_bit_out, move_rd_out, move_wr_out, move_form_out} = '0;
    {addr_out, sfr_wdata_out, index_out, move_wdata_out} = '0;
    gie_q = 1'b1;
  end
  // Direct access, set after a falling edge and taken at the next rising one.
  task automatic acc(input logic w, input logic [7:0] a, d, input logic b = 1'b0);
    {move_rd_out, move_wr_out} = 2'b00;
    {sfr_rd_out, sfr_wr_out, sfr_bit_out, addr_out, sfr_wdata_out} = {!w, w, b, a, d};
    @(negedge clk_sys_in);
  endtask : acc
  // External move in either address form.
  task automatic mv(input logic w, f, input logic [7:0] i, d);
    {sfr_rd_out, sfr_wr_out} = 2'b00;
    {move_rd_out, move_wr_out, move_form_out, index_out, move_wdata_out} = {!w, w, f, i, d};
    @(negedge clk_sys_in);
  endtask : mv
  // Release, leaving the address and index lines inverted so no stale value looks valid.
  task automatic idle();
    {sfr_rd_out, sfr_wr_out, move_rd_out, move_wr_out} = 4'h0;
    addr_out = ~addr_out;
    index_out = ~index_out;
    @(negedge clk_sys_in);
  endtask : idle
  // The alternate page is used only with interrupts held off.
  task automatic alt_enter();
    gie_save = gie_q;
    gie_q = 1'b0;
    acc(1'b1, ADDR_PAGE_SELECT, SFR_PAGE_ALT);
  endtask : alt_enter
  task automatic alt_leave();
    acc(1'b1, ADDR_PAGE_SELECT, SFR_PAGE_MAIN);
    gie_q = gie_save;
  endtask : alt_leave
endmodule : core_model
`default_nettype wire

// ==== testbench/on_chip_external_ram_and_sfr_access_decode_tb.sv ====
`default_nettype none
module on_chip_external_ram_and_sfr_access_decode_tb
  import on_chip_external_ram_sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic rst_n_in = 1'b0;
  logic sfr_rd_in, sfr_wr_in, sfr_bit_in, move_rd_in, move_wr_in, move_form_in;
  logic [7:0] direct_addr_in, sfr_wdata_in, index_reg_in, move_wdata_in;
  logic [7:0] sfr_rdata_out, register_page_select_out, move_rdata_out;
  logic sfr_rvalid_out, sfr_hit_out, sfr_bit_ok_out, on_chip_external_ram_page_bit_out, move_done_out;
  logic [15:0] data_pointer_out, move_addr_out;
  int n_mismatch = 0;
  int total_checks = 0;
  // System clock, 100 ns period.
  always #50 clk_sys_in = ~clk_sys_in;
  // Core model drives every request.
  core_model core (.clk_sys_in, .sfr_rd_out(sfr_rd_in), .sfr_wr_out(sfr_wr_in),
    .sfr_bit_out(sfr_bit_in), .addr_out(direct_addr_in), .sfr_wdata_out(sfr_wdata_in),
    .move_rd_out(move_rd_in), .move_wr_out(move_wr_in), .move_form_out(move_form_in),
    .index_out(index_reg_in), .move_wdata_out(move_wdata_in));
  // Block under test; the clock enable is dropped in one scenario.
  on_chip_external_ram_and_sfr_access_decode DUT (.clk_sys_in, .rst_n_in, .clk_en_in,
    .sfr_rd_in, .sfr_wr_in, .sfr_bit_in, .sfr_bit_pos_in(3'h0), .direct_addr_in,
    .sfr_wdata_in, .move_rd_in, .move_wr_in, .move_form_in, .index_reg_in,
    .move_wdata_in, .sfr_rdata_out, .sfr_rvalid_out, .sfr_hit_out, .sfr_bit_ok_out,
    .register_page_select_out, .data_pointer_out, .on_chip_external_ram_page_bit_out, .move_addr_out,
    .move_rdata_out, .move_done_out);
  // Compares one value and reports a difference.
  task automatic chk(input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // Holds reset low for five cycles.
  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
  endtask : do_reset
  // Reset values of all registers.
  task automatic t_reset_vals();
    chk(register_page_select_out, 16'h0000);
    chk(data_pointer_out, 16'h0000);
    core.acc(1'b0, ADDR_ON_CHIP_EXTERNAL_RAM_PAGE, 8'h00);
    chk(sfr_rvalid_out, 16'h0001);
    chk(sfr_rdata_out, 16'h0000);
    core.idle();
  endtask : t_reset_vals
  // Pointer-form moves, including the last byte and the first address past it.
  task automatic t_pointer();
    core.acc(1'b1, ADDR_DP_HIGH, 8'h01);
    core.acc(1'b1, ADDR_DP_LOW, 8'hFF);
    core.acc(1'b0, ADDR_DP_HIGH, 8'h00);
    chk(sfr_rdata_out, 16'h0001);
    chk(data_pointer_out, 16'h01FF);
    core.mv(1'b1, MOVE_BY_POINTER, 8'h00, 8'h5A);
    chk(move_done_out, 16'h0001);
    chk(move_addr_out, 16'h01FF);
    core.mv(1'b0, MOVE_BY_POINTER, 8'h00, 8'h00);
    chk(move_rdata_out, 16'h005A);
    core.acc(1'b1, ADDR_DP_HIGH, 8'h02);
    core.acc(1'b1, ADDR_DP_LOW, 8'h00);
    core.mv(1'b1, MOVE_BY_POINTER, 8'h00, 8'h77);
    core.mv(1'b0, MOVE_BY_POINTER, 8'h00, 8'h00);
    chk(move_addr_out, 16'h0200);
    chk(move_rdata_out, 16'h0000);
    // With the clock enable low a pointer write must leave no trace.
    clk_en_in = 1'b0;
    core.acc(1'b1, ADDR_DP_HIGH, 8'h33);
    chk(data_pointer_out, 16'h0200);
    clk_en_in = 1'b1;
    core.idle();
  endtask : t_pointer
  // Indexed moves on both pages of the page bit.
  task automatic t_index();
    core.acc(1'b1, ADDR_ON_CHIP_EXTERNAL_RAM_PAGE, 8'hFF);
    core.acc(1'b0, ADDR_ON_CHIP_EXTERNAL_RAM_PAGE, 8'h00);
    chk(sfr_rdata_out, 16'h0001);
    core.mv(1'b1, MOVE_BY_INDEX, 8'h34, 8'hAB);
    chk(move_addr_out, 16'h0134);
    core.mv(1'b0, MOVE_BY_INDEX, 8'h34, 8'h00);
    chk(move_rdata_out, 16'h00AB);
    core.acc(1'b1, ADDR_ON_CHIP_EXTERNAL_RAM_PAGE, 8'hFE);
    core.mv(1'b0, MOVE_BY_INDEX, 8'h34, 8'h00);
    chk(move_addr_out, 16'h0034);
    chk(move_rdata_out, 16'h0000);
    core.idle();
  endtask : t_index
  // Register paging, reserved places and bit capability.
  task automatic t_pages();
    core.alt_enter();
    chk(register_page_select_out, 16'h000F);
    core.acc(1'b1, ADDR_ON_CHIP_EXTERNAL_RAM_PAGE, 8'h01);
    core.acc(1'b0, ADDR_ON_CHIP_EXTERNAL_RAM_PAGE, 8'h00);
    chk(sfr_hit_out, 16'h0000);
    chk(on_chip_external_ram_page_bit_out, 16'h0000);
    core.acc(1'b0, ADDR_DP_HIGH, 8'h00);
    chk(sfr_rdata_out, 16'h0002);
    core.acc(1'b0, ADDR_PAGE_SELECT, 8'h00);
    chk(sfr_rdata_out, 16'h000F);
    core.alt_leave();
    chk(register_page_select_out, 16'h0000);
    core.acc(1'b0, 8'hAB, 8'h00);
    chk(sfr_hit_out, 16'h0000);
    core.acc(1'b0, 8'h40, 8'h00);
    chk(sfr_hit_out, 16'h0000);
    core.acc(1'b0, 8'h88, 8'h00, 1'b1);
    chk(sfr_bit_ok_out, 16'h0001);
    core.acc(1'b0, ADDR_DP_HIGH, 8'h00, 1'b1);
    chk(sfr_bit_ok_out, 16'h0000);
    chk(sfr_rdata_out, 16'h0000);
    core.acc(1'b1, ADDR_PAGE_SELECT, 8'h05);
    core.acc(1'b0, ADDR_DP_LOW, 8'h00);
    chk(sfr_hit_out, 16'h0000);
    core.idle();
  endtask : t_pages
  // Main sequence, with a second reset in mid-run.
  initial begin
    do_reset();
    t_reset_vals();
    t_pointer();
    t_index();
    t_pages();
    do_reset();
    t_reset_vals();
    stop_test();
  end
  // Cuts a hang short.
  initial begin
    #(100000 * 100);
    n_mismatch++;
    stop_test();
  end
endmodule : on_chip_external_ram_and_sfr_access_decode_tb
`default_nettype wire
